// *** inc/fpec_pkg.sv ***
// constants, field layouts and carrier types for the flash program/erase control block
// Overview of operation
// - array is ten erase blocks of listed sizes
// - both mode pins low: port pins choose mode
// - select bit must be 1 for flash registers
// - four flash registers share addresses with others
// - flash disabled: reads zero, writes ignored
// - write enable clear holds setup, blocks zero
// - byte registers, two bus states per access
// - no-flash variant: undefined reads, writes ignored
// - mode register loads 0x80 on reset, standby
// - verify bits writable only with write enable
// - erase bit needs write enable and setup
// - program bit needs write enable and setup
// - bit 7 read-only, always reads one
// - bit 6 is software write enable
// - bits 5 and 4 always read zero
// - bits 3, 2 select verify modes
// - bits 1, 0 select erase, program modes
// - setup bits settable only with write enable
// - select clear maps other registers, keeps contents
`default_nettype none

package fpec_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [15:0] FPEC_IDX_MODE = 16'hFF80;
  localparam logic [15:0] FPEC_IDX_SETUP = 16'hFF81;
  localparam logic [15:0] FPEC_IDX_EBR_HIGH = 16'hFF82;
  localparam logic [15:0] FPEC_IDX_EBR_LOW = 16'hFF83;
  localparam logic [15:0] FPEC_IDX_SERIAL_TIMER_CONTROL = 16'hFFC3;
  localparam logic [31:0] FPEC_ADDR_MODE = {14'h0000, FPEC_IDX_MODE, 2'b00};
  localparam logic [31:0] FPEC_ADDR_SETUP = {14'h0000, FPEC_IDX_SETUP, 2'b00};
  localparam logic [31:0] FPEC_ADDR_EBR_HIGH = {14'h0000, FPEC_IDX_EBR_HIGH, 2'b00};
  localparam logic [31:0] FPEC_ADDR_EBR_LOW = {14'h0000, FPEC_IDX_EBR_LOW, 2'b00};
  localparam logic [31:0] FPEC_ADDR_SERIAL_TIMER_CONTROL = {14'h0000, FPEC_IDX_SERIAL_TIMER_CONTROL, 2'b00};
  localparam int FPEC_SHARED_REGS = 4;

  // mode register fields
  localparam int FPEC_HWE_BIT = 7;
  localparam int FPEC_SWE_BIT = 6;
  localparam int FPEC_EV_BIT = 3;
  localparam int FPEC_PV_BIT = 2;
  localparam int FPEC_E_BIT = 1;
  localparam int FPEC_P_BIT = 0;
  // setup register fields
  localparam int FPEC_ESU_BIT = 1;
  localparam int FPEC_PSU_BIT = 0;
  // serial/timer control field that picks the flash register set
  localparam int FPEC_SEL_BIT = 3;

  // reset values and read masks
  localparam logic [7:0] FPEC_MODE_RESET = 8'h80;
  localparam logic [7:0] FPEC_ZERO_BYTE = 8'h00;
  localparam logic [7:0] FPEC_MODE_READ_MASK = 8'h4F;
  localparam logic [7:0] FPEC_SETUP_MASK = 8'h03;
  localparam logic [7:0] FPEC_EBR_HIGH_MASK = 8'h03;
  localparam logic [7:0] FPEC_EBR_LOW_MASK = 8'hFF;
  localparam logic [7:0] FPEC_EBR_LOW_NORMAL_MASK = 8'h7F;

  // variant selection; the undefined read value is arbitrary
  localparam logic FPEC_HAS_FLASH = 1'b1;
  localparam logic [7:0] FPEC_NOFLASH_READ = 8'hA5;

  // erase block sizes in kbytes, block 0 first
  localparam int FPEC_BLOCKS = 10;
  localparam int FPEC_BLOCK_KB [FPEC_BLOCKS] = '{1, 1, 1, 1, 28, 16, 8, 8, 32, 32};

  // mode pin code with on-chip flash switched off
  localparam logic [1:0] FPEC_MD_FLASH_OFF = 2'b01;
  localparam logic [1:0] FPEC_MD_BOOT = 2'b00;

  // bus timing: every register access takes this many data states
  localparam int FPEC_ACCESS_STATES = 2;
  localparam logic [1:0] FPEC_RESP_OKAY = 2'b00;

  // bus sequencer states
  typedef enum logic [0:0] {FPEC_BUS_IDLE, FPEC_BUS_WAIT} fpec_bus_e;

  // active flash operating modes
  typedef struct packed {
    logic program_mode;
    logic erase_mode;
    logic program_verify;
    logic erase_verify;
  } fpec_modes_s;

  // operating mode captured at reset release
  typedef struct packed {
    logic boot_select;
    logic [1:0] mode_pins;
    logic [2:0] port_pins;
  } fpec_opmode_s;

endpackage : fpec_pkg

`default_nettype wire

// *** core/fpec_write_gate.sv ***
// write gating of the mode and setup registers
`default_nettype none

module fpec_write_gate (
  // current register contents
  input wire logic [7:0] mode_cur,
  input wire logic [7:0] setup_cur,
  // write request
  input wire logic mode_write,
  input wire logic setup_write,
  input wire logic [7:0] wdata,
  input wire logic low_power_hold,
  // next register values
  output logic [7:0] mode_next,
  output logic [7:0] setup_next
);
  import fpec_pkg::*;

  logic swe_cur;
  logic swe_new;
  logic verify_ok;
  logic erase_ok;
  logic program_ok;
  logic [7:0] mode_wr;
  logic [7:0] setup_wr;

  // gates are judged on the bits held before the write, so a single write cannot
  // both enable and start a mode
  assign swe_cur = mode_cur[FPEC_SWE_BIT];
  assign verify_ok = swe_cur;
  assign erase_ok = swe_cur & setup_cur[FPEC_ESU_BIT];
  assign program_ok = swe_cur & setup_cur[FPEC_PSU_BIT];

  assign mode_wr[FPEC_HWE_BIT] = 1'b1;
  assign mode_wr[FPEC_SWE_BIT] = wdata[FPEC_SWE_BIT];
  assign mode_wr[5:4] = 2'b00;
  assign mode_wr[FPEC_EV_BIT] = verify_ok ? wdata[FPEC_EV_BIT] : mode_cur[FPEC_EV_BIT];
  assign mode_wr[FPEC_PV_BIT] = verify_ok ? wdata[FPEC_PV_BIT] : mode_cur[FPEC_PV_BIT];
  assign mode_wr[FPEC_E_BIT] = erase_ok ? wdata[FPEC_E_BIT] : mode_cur[FPEC_E_BIT];
  assign mode_wr[FPEC_P_BIT] = program_ok ? wdata[FPEC_P_BIT] : mode_cur[FPEC_P_BIT];

  assign setup_wr = swe_cur ? (wdata & FPEC_SETUP_MASK) : setup_cur;

  assign mode_next = low_power_hold ? FPEC_MODE_RESET : (mode_write ? mode_wr : mode_cur);
  assign swe_new = mode_next[FPEC_SWE_BIT];
  assign setup_next = (low_power_hold | ~swe_new) ? FPEC_ZERO_BYTE :
                      (setup_write ? setup_wr : setup_cur);

endmodule : fpec_write_gate

`default_nettype wire

// *** core/fpec_flash_ctrl.sv ***
// AHB-Lite slave holding the flash program/erase control registers
`default_nettype none

module fpec_flash_ctrl (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  // mode straps, sampled once after reset release
  input wire logic mode_pin_high,
  input wire logic mode_pin_low,
  input wire logic boot_select_pin_2,
  input wire logic boot_select_pin_1,
  input wire logic boot_select_pin_0,
  // standby, subactive, subsleep or watch mode in force
  input wire logic low_power_hold,
  // flash array control
  output fpec_pkg::fpec_modes_s flash_modes,
  output logic [fpec_pkg::FPEC_BLOCKS-1:0] erase_block_enable,
  output fpec_pkg::fpec_opmode_s operating_mode,
  output logic flash_enabled
);
  import fpec_pkg::*;

  // bus sequencer
  fpec_bus_e bus_state_reg;
  fpec_bus_e bus_state_next;
  logic [31:0] pend_addr_reg;
  logic pend_write_reg;
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  logic [1:0] hresp_reg;

  // registers
  logic [7:0] mode_reg;
  logic [7:0] setup_reg;
  logic [7:0] ebr_high_reg;
  logic [7:0] ebr_low_reg;
  logic [7:0] serial_timer_control_reg;
  logic [7:0] mode_next;
  logic [7:0] setup_next;
  logic [7:0] ebr_high_next;
  logic [7:0] ebr_low_next;
  logic [7:0] shared_reg [FPEC_SHARED_REGS];

  // captured mode
  logic captured_reg;
  fpec_opmode_s opmode_reg;
  fpec_opmode_s opmode_next;
  fpec_modes_s modes_reg;
  fpec_modes_s modes_next;
  logic [FPEC_BLOCKS-1:0] blocks_reg;
  logic [FPEC_BLOCKS-1:0] blocks_next;
  logic flash_on_reg;

  // decode wires
  logic accept;
  logic wr_cycle;
  logic [7:0] wbyte;
  logic hit_mode;
  logic hit_setup;
  logic hit_ebr_high;
  logic hit_ebr_low;
  logic hit_serial_timer_control;
  logic hit_shared;
  logic [1:0] shared_idx;
  logic flash_sel;
  logic flash_wr_ok;
  logic normal_cpu;
  logic [7:0] flash_rd;
  logic [7:0] shared_rd;
  logic [7:0] rd_value;
  logic [7:0] ebr_low_mask;
  logic [7:0] ebr_high_mask;

  // address phase is taken only for an active transfer while the bus is ready
  assign accept = hsel & hready & htrans[1] & (bus_state_reg == FPEC_BUS_IDLE);
  // writes land in the second state
  assign wr_cycle = (bus_state_reg == FPEC_BUS_WAIT) & pend_write_reg;
  // every register is one byte wide, carried in the low lane of a word
  assign wbyte = hwdata[7:0];

  // address decode on the held address phase
  assign hit_mode = (pend_addr_reg == FPEC_ADDR_MODE);
  assign hit_setup = (pend_addr_reg == FPEC_ADDR_SETUP);
  assign hit_ebr_high = (pend_addr_reg == FPEC_ADDR_EBR_HIGH);
  assign hit_ebr_low = (pend_addr_reg == FPEC_ADDR_EBR_LOW);
  assign hit_serial_timer_control = (pend_addr_reg == FPEC_ADDR_SERIAL_TIMER_CONTROL);
  assign hit_shared = hit_mode | hit_setup | hit_ebr_high | hit_ebr_low;
  assign shared_idx = pend_addr_reg[3:2];

  assign flash_sel = serial_timer_control_reg[FPEC_SEL_BIT];
  assign flash_wr_ok = wr_cycle & flash_sel & flash_on_reg & FPEC_HAS_FLASH;

  // normal cpu mode follows the low mode pin; it hides the upper erase blocks
  assign normal_cpu = opmode_reg.mode_pins[0];
  assign ebr_high_mask = normal_cpu ? FPEC_ZERO_BYTE : FPEC_EBR_HIGH_MASK;
  assign ebr_low_mask = normal_cpu ? FPEC_EBR_LOW_NORMAL_MASK : FPEC_EBR_LOW_MASK;

  // mode and setup gating
  fpec_write_gate u_gate (
    .mode_cur(mode_reg),
    .setup_cur(setup_reg),
    .mode_write(flash_wr_ok & hit_mode),
    .setup_write(flash_wr_ok & hit_setup),
    .wdata(wbyte),
    .low_power_hold(low_power_hold),
    .mode_next(mode_next),
    .setup_next(setup_next)
  );

  assign ebr_high_next = (low_power_hold | ~mode_next[FPEC_SWE_BIT]) ? FPEC_ZERO_BYTE :
                         ((flash_wr_ok & hit_ebr_high) ? (wbyte & ebr_high_mask) : ebr_high_reg);
  assign ebr_low_next = (low_power_hold | ~mode_next[FPEC_SWE_BIT]) ? FPEC_ZERO_BYTE :
                        ((flash_wr_ok & hit_ebr_low) ? (wbyte & ebr_low_mask) : ebr_low_reg);

  assign modes_next.program_mode = mode_next[FPEC_P_BIT];
  assign modes_next.erase_mode = mode_next[FPEC_E_BIT];
  assign modes_next.program_verify = mode_next[FPEC_PV_BIT];
  assign modes_next.erase_verify = mode_next[FPEC_EV_BIT];

  assign blocks_next = {ebr_high_next[1:0], ebr_low_next};

  assign opmode_next.boot_select = ~mode_pin_high & ~mode_pin_low;
  assign opmode_next.mode_pins = {mode_pin_high, mode_pin_low};
  assign opmode_next.port_pins = ({mode_pin_high, mode_pin_low} == FPEC_MD_BOOT) ?
                                 {boot_select_pin_2, boot_select_pin_1, boot_select_pin_0} :
                                 3'b000;

  assign flash_rd = hit_mode ? ((mode_reg & FPEC_MODE_READ_MASK) | FPEC_MODE_RESET) :
                    hit_setup ? (setup_reg & FPEC_SETUP_MASK) :
                    hit_ebr_high ? ebr_high_reg :
                    ebr_low_reg;
  assign shared_rd = shared_reg[shared_idx];

  assign rd_value = hit_serial_timer_control ? serial_timer_control_reg :
                    (hit_shared & ~flash_sel) ? shared_rd :
                    (hit_shared & ~FPEC_HAS_FLASH) ? FPEC_NOFLASH_READ :
                    (hit_shared & ~flash_on_reg) ? FPEC_ZERO_BYTE :
                    hit_shared ? flash_rd :
                    FPEC_ZERO_BYTE;

  // sequencer next state: one wait state for every access
  always_comb begin
    bus_state_next = bus_state_reg;
    unique case (bus_state_reg)
      FPEC_BUS_IDLE: begin
        if (accept) begin
          bus_state_next = FPEC_BUS_WAIT;
        end
      end
      FPEC_BUS_WAIT: begin
        bus_state_next = FPEC_BUS_IDLE;
      end
    endcase
  end

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_reg <= FPEC_BUS_IDLE;
      pend_addr_reg <= 32'h00000000;
      pend_write_reg <= 1'b0;
    end else begin
      bus_state_reg <= bus_state_next;
      if (accept) begin
        pend_addr_reg <= {haddr[31:2], 2'b00};
        pend_write_reg <= hwrite;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h00000000;
      hresp_reg <= FPEC_RESP_OKAY;
    end else begin
      hreadyout_reg <= ~accept;
      hresp_reg <= FPEC_RESP_OKAY;
      if (bus_state_reg == FPEC_BUS_WAIT) begin
        hrdata_reg <= {24'h000000, rd_value};
      end
    end
  end

  // flash registers keep contents while deselected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= FPEC_MODE_RESET;
      setup_reg <= FPEC_ZERO_BYTE;
      ebr_high_reg <= FPEC_ZERO_BYTE;
      ebr_low_reg <= FPEC_ZERO_BYTE;
    end else begin
      mode_reg <= mode_next;
      setup_reg <= setup_next;
      ebr_high_reg <= ebr_high_next;
      ebr_low_reg <= ebr_low_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_timer_control_reg <= FPEC_ZERO_BYTE;
    end else if (wr_cycle & hit_serial_timer_control) begin
      serial_timer_control_reg <= wbyte;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < FPEC_SHARED_REGS; gi++) begin : g_shared
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          shared_reg[gi] <= FPEC_ZERO_BYTE;
        end else if (wr_cycle & hit_shared & ~flash_sel & (shared_idx == 2'(gi))) begin
          shared_reg[gi] <= wbyte;
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      captured_reg <= 1'b0;
      opmode_reg <= '0;
      flash_on_reg <= 1'b0;
    end else if (!captured_reg) begin
      captured_reg <= 1'b1;
      opmode_reg <= opmode_next;
      flash_on_reg <= ({mode_pin_high, mode_pin_low} != FPEC_MD_FLASH_OFF) & FPEC_HAS_FLASH;
    end
  end

  // registered copies for the array side; they track the next values so they
  // stay aligned with the registers themselves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      modes_reg <= '0;
      blocks_reg <= '0;
    end else begin
      modes_reg <= modes_next;
      blocks_reg <= blocks_next;
    end
  end

  // outputs straight from flops
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign flash_modes = modes_reg;
  assign erase_block_enable = blocks_reg;
  assign operating_mode = opmode_reg;
  assign flash_enabled = flash_on_reg;

endmodule : fpec_flash_ctrl

`default_nettype wire

// *** test/fpec_flash_ctrl_asserts.sv ***
// concurrent checks on the flash program/erase control ports
`default_nettype none

module fpec_flash_ctrl_asserts (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus side
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  // flash side
  input wire logic low_power_hold,
  input wire fpec_pkg::fpec_modes_s flash_modes,
  input wire logic [fpec_pkg::FPEC_BLOCKS-1:0] erase_block_enable,
  input wire fpec_pkg::fpec_opmode_s operating_mode,
  input wire logic flash_enabled
);
  import fpec_pkg::*;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // an address phase the slave takes
  wire logic take = hsel && hready && htrans[1] && hreadyout;

  // bus answer: one wait state, always OKAY, byte in the low lane
  chk_one_wait: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after exactly one wait state");
  chk_resp_okay: assert property (hresp == FPEC_RESP_OKAY)
    else $error("response other than okay");
  chk_byte_lane: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
    else $error("read data outside the low byte");

  // standby style hold wipes modes and block selects at every edge
  chk_hold_clears: assert property (low_power_hold |=>
    flash_modes == 4'h0 && erase_block_enable == '0)
    else $error("hold did not clear modes or blocks");

  // straps: port pins only count when both mode pins are low
  chk_boot_pins: assert property (operating_mode.boot_select |->
    operating_mode.mode_pins == FPEC_MD_BOOT)
    else $error("boot select without both mode pins low");
  chk_port_gate: assert property (!operating_mode.boot_select |->
    operating_mode.port_pins == 3'b000)
    else $error("port pins passed outside boot straps");
  chk_flash_off: assert property (
    operating_mode.mode_pins == FPEC_MD_FLASH_OFF |-> !flash_enabled)
    else $error("flash enabled in flash-off mode");

  // modes and blocks move only after a data phase or a hold
  chk_modes_cause: assert property (!$stable(flash_modes) |->
    $past(low_power_hold) || !$past(hreadyout))
    else $error("modes changed without a write");
  chk_blocks_cause: assert property (!$stable(erase_block_enable) |->
    $past(low_power_hold) || !$past(hreadyout))
    else $error("block selects changed without a write");
  chk_erase_cause: assert property ($rose(flash_modes.erase_mode) |->
    $past(hwdata[FPEC_E_BIT]))
    else $error("erase mode rose without its bit written");
  chk_pv_cause: assert property ($rose(flash_modes.program_verify) |->
    $past(hwdata[FPEC_PV_BIT]))
    else $error("program verify rose without its bit written");

  // main scenarios reached
  cov_program: cover property ($rose(flash_modes.program_mode));
  cov_erase: cover property ($rose(flash_modes.erase_mode));
  cov_hold: cover property (low_power_hold ##1 !low_power_hold);
endmodule : fpec_flash_ctrl_asserts

bind fpec_flash_ctrl fpec_flash_ctrl_asserts i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .low_power_hold(low_power_hold), .flash_modes(flash_modes),
  .erase_block_enable(erase_block_enable), .operating_mode(operating_mode),
  .flash_enabled(flash_enabled)
);

`default_nettype wire

// *** test/fpec_flash_ctrl_tb_top.sv ***
// self-checking bench for the flash program/erase control block
`default_nettype none

module fpec_flash_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fpec_pkg::*;

  // one row: write flag, address, data or expected read byte, expected modes
  typedef struct packed {
    logic w;
    logic [31:0] a;
    logic [7:0] d;
    logic [3:0] m;
  } fpec_row_s;

  localparam logic RD = 1'b0;
  localparam logic WR = 1'b1;
  localparam logic [31:0] AM = FPEC_ADDR_MODE;
  localparam logic [31:0] AS = FPEC_ADDR_SETUP;
  localparam logic [31:0] AH = FPEC_ADDR_EBR_HIGH;
  localparam logic [31:0] AL = FPEC_ADDR_EBR_LOW;
  localparam logic [31:0] SC = FPEC_ADDR_SERIAL_TIMER_CONTROL;

  // modes nibble: program, erase, program verify, erase verify
  localparam fpec_row_s ROWS [41] = '{
    '{RD, SC, 8'h00, 4'h0}, '{WR, SC, 8'h08, 4'h0}, '{RD, AM, 8'h80, 4'h0},
    '{RD, AS, 8'h00, 4'h0}, '{RD, AH, 8'h00, 4'h0}, '{RD, AL, 8'h00, 4'h0},
    '{WR, AM, 8'h0C, 4'h0}, '{RD, AM, 8'h80, 4'h0},
    '{WR, AS, 8'h03, 4'h0}, '{RD, AS, 8'h00, 4'h0},
    '{WR, AL, 8'h01, 4'h0}, '{RD, AL, 8'h00, 4'h0},
    '{WR, AM, 8'h73, 4'h0}, '{RD, AM, 8'hC0, 4'h0},
    '{WR, AM, 8'h48, 4'h1}, '{WR, AM, 8'h44, 4'h2}, '{WR, AM, 8'h40, 4'h0},
    '{WR, AS, 8'h01, 4'h0}, '{WR, AM, 8'h42, 4'h0}, '{WR, AM, 8'h41, 4'h8},
    '{RD, AM, 8'hC1, 4'h8}, '{WR, AM, 8'h40, 4'h0}, '{WR, AS, 8'h02, 4'h0},
    '{WR, AM, 8'h41, 4'h0}, '{WR, AM, 8'h42, 4'h4}, '{RD, AS, 8'h02, 4'h4},
    '{WR, AM, 8'h40, 4'h0}, '{WR, AL, 8'hFF, 4'h0}, '{WR, AH, 8'h03, 4'h0},
    '{RD, AL, 8'hFF, 4'h0}, '{RD, AH, 8'h03, 4'h0},
    '{WR, SC, 8'h00, 4'h0}, '{WR, AM, 8'h55, 4'h0}, '{RD, AM, 8'h55, 4'h0},
    '{WR, SC, 8'h08, 4'h0}, '{RD, AM, 8'hC0, 4'h0}, '{RD, AL, 8'hFF, 4'h0},
    '{WR, AM, 8'h00, 4'h0}, '{RD, AS, 8'h00, 4'h0}, '{RD, AH, 8'h00, 4'h0},
    '{RD, 32'h00000100, 8'h00, 4'h0}
  };

  logic hclk, hresetn, hsel, hwrite, hreadyout, low_power_hold, flash_enabled;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic [4:0] straps; // high, low, pin 2, pin 1, pin 0
  fpec_modes_s flash_modes;
  logic [FPEC_BLOCKS-1:0] erase_block_enable;
  fpec_opmode_s operating_mode;
  int n_fail, checked;

  // hready is the lone slave's own ready
  fpec_flash_ctrl i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mode_pin_high(straps[4]),
    .mode_pin_low(straps[3]), .boot_select_pin_2(straps[2]),
    .boot_select_pin_1(straps[1]), .boot_select_pin_0(straps[0]),
    .low_power_hold(low_power_hold), .flash_modes(flash_modes),
    .erase_block_enable(erase_block_enable), .operating_mode(operating_mode),
    .flash_enabled(flash_enabled)
  );

  // 25 MHz bus clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // bounded wait for ready; a stuck bus ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      final_report();
    end
  endtask : wait_ready

  // single word transfer; the register byte rides in the low lane
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    wait_ready();
    rd = hrdata;
  endtask : xfer

  // reset held three cycles; straps settle before release
  task automatic do_reset(input logic [4:0] s);
    hresetn <= 1'b0;
    straps <= s;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask : do_reset

  // main sequence: table first, then hold, boot straps, normal cpu straps and flash-off
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    straps = 5'b10000;
    low_power_hold = 1'b0;
    n_fail = 0;
    checked = 0;
    do_reset(5'b10000);
    chk("opmode", 32'(operating_mode), 32'h10);
    foreach (ROWS[i]) begin
      xfer(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      if (ROWS[i].w == RD) begin
        chk("read data", rd, {24'h000000, ROWS[i].d});
      end
      chk("flash modes", 32'(flash_modes), {28'h0000000, ROWS[i].m});
      chk("response", 32'(hresp), 32'h00000000);
    end
    xfer(WR, AM, 8'h40);
    xfer(WR, AS, 8'h01);
    xfer(WR, AL, 8'h10);
    chk("blocks", 32'(erase_block_enable), 32'h00000010);
    // program mode live, so the hold below has a mode to wipe as well
    xfer(WR, AM, 8'h41);
    chk("program before hold", 32'(flash_modes), 32'h00000008);
    low_power_hold <= 1'b1;
    repeat (2) @(posedge hclk);
    low_power_hold <= 1'b0;
    chk("modes after hold", 32'(flash_modes), 32'h00000000);
    chk("blocks after hold", 32'(erase_block_enable), 32'h00000000);
    xfer(RD, AM, 8'h00);
    chk("mode after hold", rd, 32'h00000080);
    xfer(RD, AS, 8'h00);
    chk("setup after hold", rd, 32'h00000000);
    do_reset(5'b00101);
    chk("boot opmode", 32'(operating_mode), 32'h25);
    chk("boot flash on", 32'(flash_enabled), 32'h1);
    // normal cpu straps hide the upper erase block bits
    do_reset(5'b11000);
    chk("normal opmode", 32'(operating_mode), 32'h18);
    xfer(WR, SC, 8'h08);
    xfer(WR, AM, 8'h40);
    xfer(WR, AH, 8'h03);
    xfer(WR, AL, 8'hFF);
    xfer(RD, AH, 8'h00);
    chk("normal block high", rd, 32'h00000000);
    xfer(RD, AL, 8'h00);
    chk("normal block low", rd, 32'h0000007F);
    chk("normal blocks", 32'(erase_block_enable), 32'h0000007F);
    do_reset(5'b01111);
    chk("off opmode", 32'(operating_mode), 32'h08);
    chk("flash off", 32'(flash_enabled), 32'h0);
    xfer(WR, SC, 8'h08);
    xfer(WR, AM, 8'h40);
    xfer(RD, AM, 8'h00);
    chk("off mode read", rd, 32'h00000000);
    final_report();
  end
endmodule : fpec_flash_ctrl_tb_top

`default_nettype wire
